// *** sim/cpu_control_register_set_bench.sv ***
// Self-checking bench for crs_regset, driven through crs_core_model.
// Assumes crs_pkg and crs_core_model are compiled first.
`timescale 1ns/100ps

module cpu_control_register_set_bench;
    import crs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] gpr_rd_a_idx, gpr_rd_b_idx, gpr_wr_idx, cr_rd_idx, cr_wr_idx;
    logic gpr_we, cr_we, pc_we, fint_accept, fp_op_done, fp_trap;
    logic [4:0] fp_exc, en, e, stk;
    logic [31:0] gpr_wr_data, cr_wr_data, pc_wr_data, gpr_rd_a_data, gpr_rd_b_data;
    logic [31:0] cr_rd_data, prog_counter, status_word, stack_ptr, vector_table_base;
    logic [31:0] fast_vector_addr, float_status_word, v, w, gm [16], cm [9];
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;

    always #10 clk = ~clk;

    crs_regset uut (
        .clk, .rst, .gpr_rd_a_idx, .gpr_rd_a_data, .gpr_rd_b_idx, .gpr_rd_b_data,
        .gpr_we, .gpr_wr_idx, .gpr_wr_data, .cr_rd_idx, .cr_rd_data, .cr_we,
        .cr_wr_idx, .cr_wr_data, .pc_we, .pc_wr_data, .prog_counter, .status_word,
        .stack_ptr, .vector_table_base, .fint_accept, .fast_vector_addr,
        .fp_op_done, .fp_exc, .fp_trap, .float_status_word
    );
    crs_core_model core (
        .clk, .gpr_rd_a_idx, .gpr_rd_b_idx, .gpr_we, .gpr_wr_idx, .gpr_wr_data,
        .cr_rd_idx, .cr_we, .cr_wr_idx, .cr_wr_data, .pc_we, .pc_wr_data,
        .fint_accept, .fp_op_done, .fp_exc
    );

    // ********************************
    // Helpers and run control
    // ********************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
        core.rd(a, b, c);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count = fail_count + 1;
            tally_and_finish();
        end
    end

    initial begin
        v = $urandom(81);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(prog_counter | status_word | stack_ptr | float_status_word, 32'h0);
        for (int i = 1; i < 16; i++) begin
            gm[i] = $urandom;
            core.gpr_wr(i[3:0], gm[i]);
        end
        for (int i = 1; i < 16; i++) begin
            rd(i[3:0], 4'(16 - i), 4'h0);
            chk(gpr_rd_a_data, gm[i]);
            chk(gpr_rd_b_data, gm[16 - i]);
        end
        // Interrupt stack selected after reset, then user stack
        v = $urandom & 32'hffff_fffc;
        core.gpr_wr(4'h0, v);
        rd(4'h0, 4'h1, CRS_CR_IRQ_SP);
        chk(gpr_rd_a_data, v);
        chk(cr_rd_data, v);
        chk(stack_ptr, v);
        core.cr_wr(CRS_CR_STATUS, 32'h1 << CRS_STATUS_SEL_BIT);
        w = $urandom & 32'hffff_fffc;
        core.gpr_wr(4'h0, w);
        rd(4'h0, 4'h0, CRS_CR_USER_SP);
        chk(gpr_rd_a_data, w);
        chk(gpr_rd_b_data, w);
        chk(cr_rd_data, w);
        rd(4'h0, 4'h0, CRS_CR_IRQ_SP);
        chk(cr_rd_data, v);
        // Every control index, unmapped ones included
        for (int i = 0; i < 16; i++) begin
            v = $urandom & 32'hffff_fffc;
            if (i < 9) cm[i] = v;
            core.cr_wr(i[3:0], v);
        end
        for (int i = 0; i < 16; i++) begin
            rd(4'h0, 4'h0, i[3:0]);
            chk(cr_rd_data, (i < 9) ? cm[i] : 32'h0);
        end
        chk(vector_table_base, cm[4]);
        chk(prog_counter, cm[1]);
        chk(stack_ptr, cm[0][CRS_STATUS_SEL_BIT] ? cm[2] : cm[3]);
        chk(fast_vector_addr, cm[7]);
        chk(status_word, cm[0]);
        cm[1] = $urandom;
        core.pc_ld(cm[1]);
        #1;
        chk(prog_counter, cm[1]);
        core.fint();
        #1;
        chk(prog_counter, cm[7]);
        chk(status_word, cm[0]);
        rd(4'h0, 4'h0, CRS_CR_SAVED_PC);
        chk(cr_rd_data, cm[1]);
        rd(4'h0, 4'h0, CRS_CR_SAVED_STATUS);
        chk(cr_rd_data, cm[0]);
        // Floating-point ops with all, none and random enables
        for (int k = 0; k < 3; k++) begin
            en = (k == 0) ? 5'h00 : (k == 1) ? 5'h1f : 5'($urandom);
            stk = 5'h00;
            core.cr_wr(CRS_CR_FP_STATUS, 32'(en) << CRS_FP_EN_LSB);
            for (int j = 0; j < 6; j++) begin
                e = (j == 0) ? 5'h1f : 5'($urandom);
                core.fp_op(e);
                #1;
                stk = stk | (e & ~en);
                w = (32'(stk) << CRS_FP_STICKY_LSB) | (32'(en) << CRS_FP_EN_LSB);
                chk({31'h0, fp_trap}, {31'h0, |(e & en)});
                chk(float_status_word, w | (32'(e & en) << CRS_FP_CAUSE_LSB));
                @(posedge clk);
                #1;
                chk({31'h0, fp_trap}, 32'h0);
            end
        end
        // Sticky set and software clear in one cycle: the set wins
        core.fp_op_wr(5'h1f, 32'h0);
        #1;
        stk = ~en;
        w = (32'(stk) << CRS_FP_STICKY_LSB) | (32'(en) << CRS_FP_CAUSE_LSB);
        chk(float_status_word, w);
        chk({31'h0, fp_trap}, {31'h0, |en});
        core.cr_wr(CRS_CR_FP_STATUS, 32'h0);
        #1;
        chk(float_status_word, 32'h0);
        tally_and_finish();
    end
endmodule

// *** sim/crs_core_model.sv ***
// Core-side model: register transfers, PC loads, fast interrupts, FP ops.
// Assumes a crs_regset on the same clk; requests change just after a rising edge.
`timescale 1ns/100ps

module crs_core_model
    import crs_pkg::*;
(
    input wire logic clk,
    output logic [3:0] gpr_rd_a_idx,
    output logic [3:0] gpr_rd_b_idx,
    output logic gpr_we,
    output logic [3:0] gpr_wr_idx,
    output logic [31:0] gpr_wr_data,
    output logic [3:0] cr_rd_idx,
    output logic cr_we,
    output logic [3:0] cr_wr_idx,
    output logic [31:0] cr_wr_data,
    output logic pc_we,
    output logic [31:0] pc_wr_data,
    output logic fint_accept,
    output logic fp_op_done,
    output logic [4:0] fp_exc
);
    // ********************************
    // Request tasks
    // ********************************
    initial begin
        {gpr_rd_a_idx, gpr_rd_b_idx, gpr_wr_idx, cr_rd_idx, cr_wr_idx} = '0;
        {gpr_we, cr_we, pc_we, fint_accept, fp_op_done, fp_exc} = '0;
        {gpr_wr_data, cr_wr_data, pc_wr_data} = '0;
    end

    task automatic gpr_wr(input logic [3:0] i, input logic [31:0] d);
        @(posedge clk);
        gpr_we <= 1'b1;
        gpr_wr_idx <= i;
        gpr_wr_data <= (i == 4'h0) ? {d[31:2], 2'b00} : d;
        @(posedge clk);
        gpr_we <= 1'b0;
        gpr_wr_data <= ~d;
    endtask

    task automatic cr_wr(input logic [3:0] i, input logic [31:0] d);
        @(posedge clk);
        cr_we <= 1'b1;
        cr_wr_idx <= i;
        if (i inside {CRS_CR_USER_SP, CRS_CR_IRQ_SP, CRS_CR_VEC_BASE}) begin
            cr_wr_data <= {d[31:2], 2'b00};
        end else begin
            cr_wr_data <= d;
        end
        @(posedge clk);
        cr_we <= 1'b0;
        cr_wr_data <= ~d;
    endtask

    task automatic pc_ld(input logic [31:0] d);
        @(posedge clk);
        pc_we <= 1'b1;
        pc_wr_data <= d;
        @(posedge clk);
        pc_we <= 1'b0;
        pc_wr_data <= ~d;
    endtask

    task automatic fint();
        @(posedge clk);
        fint_accept <= 1'b1;
        @(posedge clk);
        fint_accept <= 1'b0;
    endtask

    task automatic fp_op(input logic [4:0] e);
        @(posedge clk);
        fp_op_done <= 1'b1;
        fp_exc <= e;
        @(posedge clk);
        fp_op_done <= 1'b0;
        fp_exc <= ~e;
    endtask

    // Op completion and floating-point status word write in one cycle
    task automatic fp_op_wr(input logic [4:0] e, input logic [31:0] d);
        @(posedge clk);
        cr_we <= 1'b1;
        cr_wr_idx <= CRS_CR_FP_STATUS;
        cr_wr_data <= d;
        fp_op_done <= 1'b1;
        fp_exc <= e;
        @(posedge clk);
        cr_we <= 1'b0;
        fp_op_done <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
        @(posedge clk);
        gpr_rd_a_idx <= a;
        gpr_rd_b_idx <= b;
        cr_rd_idx <= c;
        @(posedge clk);
    endtask
endmodule

// *** src/crs_pkg.sv ***
// Constants for the CPU general-purpose and control register set.
// Assumes a single core clock with a synchronous active-high reset.
// Overview of operation
// - Sixteen general registers exist; one to fifteen serve as data or address registers.
// - Register zero is the active stack pointer, so its accesses reach the selected pointer.
// - The status word's stack select bit picks the interrupt or the user stack pointer.
// - The vector table base gives the table start; software writes it as a multiple of four.
// - The program counter always holds the address of the instruction being executed.
// - Accepting a fast interrupt copies the program counter into the saved program counter.
// - A fast interrupt copies the status word into the saved status word of equal layout.
// - A fast interrupt branches to the fast vector address instead of a fetched table vector.
// - An enabled floating-point exception raises exception handling and sets its cause flag.
// - A masked exception sets its sticky flag, which stays one until software writes zero.
package crs_pkg;

    // ********************************
    // Widths and counts
    // ********************************
    localparam int CRS_XLEN = 32;
    localparam int CRS_NUM_GPR = 16;
    localparam int CRS_GIDX_W = 4;
    localparam int CRS_CIDX_W = 4;
    localparam int CRS_NEXC = 5;

    // ********************************
    // Control register indices
    // ********************************
    localparam logic [3:0] CRS_CR_STATUS = 4'h0;
    localparam logic [3:0] CRS_CR_PC = 4'h1;
    localparam logic [3:0] CRS_CR_USER_SP = 4'h2;
    localparam logic [3:0] CRS_CR_IRQ_SP = 4'h3;
    localparam logic [3:0] CRS_CR_VEC_BASE = 4'h4;
    localparam logic [3:0] CRS_CR_SAVED_PC = 4'h5;
    localparam logic [3:0] CRS_CR_SAVED_STATUS = 4'h6;
    localparam logic [3:0] CRS_CR_FAST_VEC = 4'h7;
    localparam logic [3:0] CRS_CR_FP_STATUS = 4'h8;

    // ********************************
    // Field positions
    // ********************************
    localparam int CRS_STATUS_SEL_BIT = 17;
    // Exception order within each field: V, O, Z, U, X from bit 0 up
    localparam int CRS_FP_CAUSE_LSB = 2;
    localparam int CRS_FP_EN_LSB = 10;
    localparam int CRS_FP_STICKY_LSB = 26;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [31:0] CRS_RST_WORD = 32'h0000_0000;
    localparam logic [4:0] CRS_RST_EXC = 5'h00;

endpackage

// *** src/crs_regset.sv ***
// CPU general-purpose and control register set.
// Driven by the core's execution and interrupt entry logic on clk.
`timescale 1ns/100ps

module crs_regset
    import crs_pkg::*;
#(
    parameter int DATA_W = CRS_XLEN
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [CRS_GIDX_W-1:0] gpr_rd_a_idx,
    output logic [DATA_W-1:0] gpr_rd_a_data,
    input wire logic [CRS_GIDX_W-1:0] gpr_rd_b_idx,
    output logic [DATA_W-1:0] gpr_rd_b_data,
    input wire logic gpr_we,
    input wire logic [CRS_GIDX_W-1:0] gpr_wr_idx,
    input wire logic [DATA_W-1:0] gpr_wr_data,
    input wire logic [CRS_CIDX_W-1:0] cr_rd_idx,
    output logic [DATA_W-1:0] cr_rd_data,
    input wire logic cr_we,
    input wire logic [CRS_CIDX_W-1:0] cr_wr_idx,
    input wire logic [DATA_W-1:0] cr_wr_data,
    input wire logic pc_we,
    input wire logic [DATA_W-1:0] pc_wr_data,
    output logic [DATA_W-1:0] prog_counter,
    output logic [DATA_W-1:0] status_word,
    output logic [DATA_W-1:0] stack_ptr,
    output logic [DATA_W-1:0] vector_table_base,
    input wire logic fint_accept,
    output logic [DATA_W-1:0] fast_vector_addr,
    input wire logic fp_op_done,
    input wire logic [CRS_NEXC-1:0] fp_exc,
    output logic fp_trap,
    output logic [DATA_W-1:0] float_status_word
);

    // ********************************
    // State
    // ********************************
    logic [DATA_W-1:0] gpr_q [1:CRS_NUM_GPR-1];
    logic [DATA_W-1:0] gpr_d [1:CRS_NUM_GPR-1];
    logic [DATA_W-1:0] irq_stack_ptr_q, irq_stack_ptr_d;
    logic [DATA_W-1:0] user_stack_ptr_q, user_stack_ptr_d;
    logic [DATA_W-1:0] status_word_q, status_word_d;
    logic [DATA_W-1:0] pc_q, pc_d;
    logic [DATA_W-1:0] vector_table_base_q, vector_table_base_d;
    logic [DATA_W-1:0] saved_prog_counter_q, saved_prog_counter_d;
    logic [DATA_W-1:0] saved_status_word_q, saved_status_word_d;
    logic [DATA_W-1:0] fast_vector_addr_q, fast_vector_addr_d;
    logic [DATA_W-1:0] float_status_word_q, float_status_word_d;
    logic [DATA_W-1:0] rd_a_q, rd_a_d;
    logic [DATA_W-1:0] rd_b_q, rd_b_d;
    logic [DATA_W-1:0] cr_rd_q, cr_rd_d;
    logic fp_trap_q, fp_trap_d;

    logic [CRS_NEXC-1:0] exc_enable_bits;
    logic [CRS_NEXC-1:0] cause_flags;
    logic [CRS_NEXC-1:0] sticky_flags;
    logic [CRS_NEXC-1:0] exc_taken;
    logic [CRS_NEXC-1:0] exc_masked;

    // ********************************
    // Functions
    // ********************************
    // Active stack pointer picked by the status word select bit
    function automatic logic [DATA_W-1:0] sel_sp(
        input logic [DATA_W-1:0] sw,
        input logic [DATA_W-1:0] irq_sp,
        input logic [DATA_W-1:0] usr_sp
    );
        sel_sp = sw[CRS_STATUS_SEL_BIT] ? usr_sp : irq_sp;
    endfunction

    // General-purpose register read with register zero as stack pointer
    function automatic logic [DATA_W-1:0] rd_gpr(
        input logic [CRS_GIDX_W-1:0] idx,
        input logic [DATA_W-1:0] regs [1:CRS_NUM_GPR-1],
        input logic [DATA_W-1:0] sp
    );
        if (idx == '0) begin
            rd_gpr = sp;
        end else begin
            rd_gpr = regs[idx];
        end
    endfunction

    // ********************************
    // Floating-point fields
    // ********************************
    assign exc_enable_bits = float_status_word_q[CRS_FP_EN_LSB +: CRS_NEXC];
    assign cause_flags = float_status_word_q[CRS_FP_CAUSE_LSB +: CRS_NEXC];
    assign sticky_flags = float_status_word_q[CRS_FP_STICKY_LSB +: CRS_NEXC];
    assign exc_taken = fp_exc & exc_enable_bits;
    assign exc_masked = fp_exc & ~exc_enable_bits;

    // ********************************
    // Next-state logic
    // ********************************
    always_comb begin
        gpr_d = gpr_q;
        irq_stack_ptr_d = irq_stack_ptr_q;
        user_stack_ptr_d = user_stack_ptr_q;
        status_word_d = status_word_q;
        pc_d = pc_q;
        vector_table_base_d = vector_table_base_q;
        saved_prog_counter_d = saved_prog_counter_q;
        saved_status_word_d = saved_status_word_q;
        fast_vector_addr_d = fast_vector_addr_q;
        float_status_word_d = float_status_word_q;
        fp_trap_d = 1'b0;

        // Control register transfers, all 32-bit read/write
        if (cr_we) begin
            case (cr_wr_idx)
                CRS_CR_STATUS: status_word_d = cr_wr_data;
                CRS_CR_PC: pc_d = cr_wr_data;
                CRS_CR_USER_SP: user_stack_ptr_d = cr_wr_data;
                CRS_CR_IRQ_SP: irq_stack_ptr_d = cr_wr_data;
                CRS_CR_VEC_BASE: vector_table_base_d = cr_wr_data;
                CRS_CR_SAVED_PC: saved_prog_counter_d = cr_wr_data;
                CRS_CR_SAVED_STATUS: saved_status_word_d = cr_wr_data;
                CRS_CR_FAST_VEC: fast_vector_addr_d = cr_wr_data;
                CRS_CR_FP_STATUS: float_status_word_d = cr_wr_data;
                default: ;
            endcase
        end

        // General-purpose write, register zero goes to the selected stack
        if (gpr_we) begin
            if (gpr_wr_idx == '0) begin
                if (status_word_q[CRS_STATUS_SEL_BIT]) begin
                    user_stack_ptr_d = gpr_wr_data;
                end else begin
                    irq_stack_ptr_d = gpr_wr_data;
                end
            end else begin
                gpr_d[gpr_wr_idx] = gpr_wr_data;
            end
        end

        // Instruction advance
        if (pc_we) begin
            pc_d = pc_wr_data;
        end

        // Fast interrupt entry wins over everything else on these registers
        if (fint_accept) begin
            saved_prog_counter_d = pc_q;
            saved_status_word_d = status_word_q;
            pc_d = fast_vector_addr_q;
        end

        // Floating-point result; sticky set wins over a software clear
        if (fp_op_done) begin
            float_status_word_d[CRS_FP_CAUSE_LSB +: CRS_NEXC] = exc_taken;
            float_status_word_d[CRS_FP_STICKY_LSB +: CRS_NEXC] =
                float_status_word_d[CRS_FP_STICKY_LSB +: CRS_NEXC] | exc_masked;
            fp_trap_d = |exc_taken;
        end
    end

    // Registered read ports
    always_comb begin
        rd_a_d = rd_gpr(gpr_rd_a_idx, gpr_q,
                        sel_sp(status_word_q, irq_stack_ptr_q, user_stack_ptr_q));
        rd_b_d = rd_gpr(gpr_rd_b_idx, gpr_q,
                        sel_sp(status_word_q, irq_stack_ptr_q, user_stack_ptr_q));
        case (cr_rd_idx)
            CRS_CR_STATUS: cr_rd_d = status_word_q;
            CRS_CR_PC: cr_rd_d = pc_q;
            CRS_CR_USER_SP: cr_rd_d = user_stack_ptr_q;
            CRS_CR_IRQ_SP: cr_rd_d = irq_stack_ptr_q;
            CRS_CR_VEC_BASE: cr_rd_d = vector_table_base_q;
            CRS_CR_SAVED_PC: cr_rd_d = saved_prog_counter_q;
            CRS_CR_SAVED_STATUS: cr_rd_d = saved_status_word_q;
            CRS_CR_FAST_VEC: cr_rd_d = fast_vector_addr_q;
            CRS_CR_FP_STATUS: cr_rd_d = float_status_word_q;
            default: cr_rd_d = CRS_RST_WORD;
        endcase
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 1; i < CRS_NUM_GPR; i++) begin
                gpr_q[i] <= CRS_RST_WORD;
            end
            irq_stack_ptr_q <= CRS_RST_WORD;
            user_stack_ptr_q <= CRS_RST_WORD;
            status_word_q <= CRS_RST_WORD;
            pc_q <= CRS_RST_WORD;
            vector_table_base_q <= CRS_RST_WORD;
            saved_prog_counter_q <= CRS_RST_WORD;
            saved_status_word_q <= CRS_RST_WORD;
            fast_vector_addr_q <= CRS_RST_WORD;
            float_status_word_q <= CRS_RST_WORD;
            rd_a_q <= CRS_RST_WORD;
            rd_b_q <= CRS_RST_WORD;
            cr_rd_q <= CRS_RST_WORD;
            fp_trap_q <= 1'b0;
        end else begin
            gpr_q <= gpr_d;
            irq_stack_ptr_q <= irq_stack_ptr_d;
            user_stack_ptr_q <= user_stack_ptr_d;
            status_word_q <= status_word_d;
            pc_q <= pc_d;
            vector_table_base_q <= vector_table_base_d;
            saved_prog_counter_q <= saved_prog_counter_d;
            saved_status_word_q <= saved_status_word_d;
            fast_vector_addr_q <= fast_vector_addr_d;
            float_status_word_q <= float_status_word_d;
            rd_a_q <= rd_a_d;
            rd_b_q <= rd_b_d;
            cr_rd_q <= cr_rd_d;
            fp_trap_q <= fp_trap_d;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign gpr_rd_a_data = rd_a_q;
    assign gpr_rd_b_data = rd_b_q;
    assign cr_rd_data = cr_rd_q;
    assign prog_counter = pc_q;
    assign status_word = status_word_q;
    assign stack_ptr = sel_sp(status_word_q, irq_stack_ptr_q, user_stack_ptr_q);
    assign vector_table_base = vector_table_base_q;
    assign fast_vector_addr = fast_vector_addr_q;
    assign fp_trap = fp_trap_q;
    assign float_status_word = float_status_word_q;

    // ********************************
    // Assertions
    // ********************************
    AST_GPR_WRITE: assert property (@(posedge clk) disable iff (rst)
        gpr_we && gpr_wr_idx != '0 |=> gpr_q[$past(gpr_wr_idx)] == $past(gpr_wr_data))
        else $error("General register write lost");

    AST_SP_WRITE: assert property (@(posedge clk) disable iff (rst)
        gpr_we && gpr_wr_idx == '0 && !cr_we
        |=> stack_ptr == $past(gpr_wr_data))
        else $error("Register zero write missed the active stack pointer");

    AST_SP_READ: assert property (@(posedge clk) disable iff (rst)
        gpr_rd_a_idx == '0
        |=> gpr_rd_a_data == ($past(status_word_q[CRS_STATUS_SEL_BIT]) ?
            $past(user_stack_ptr_q) : $past(irq_stack_ptr_q)))
        else $error("Register zero read not routed by select bit");

    AST_PC_LOAD: assert property (@(posedge clk) disable iff (rst)
        pc_we && !fint_accept |=> prog_counter == $past(pc_wr_data))
        else $error("Program counter not loaded");

    AST_SAVED_PC: assert property (@(posedge clk) disable iff (rst)
        fint_accept |=> saved_prog_counter_q == $past(prog_counter))
        else $error("Saved program counter wrong");

    AST_SAVED_STATUS: assert property (@(posedge clk) disable iff (rst)
        fint_accept |=> saved_status_word_q == $past(status_word))
        else $error("Saved status word wrong");

    AST_FINT_BRANCH: assert property (@(posedge clk) disable iff (rst)
        fint_accept |=> prog_counter == $past(fast_vector_addr))
        else $error("Fast interrupt did not branch to its vector");

    AST_CAUSE: assert property (@(posedge clk) disable iff (rst)
        fp_op_done |=> cause_flags == $past(fp_exc & exc_enable_bits)
        && fp_trap == |$past(fp_exc & exc_enable_bits) ##1 !fp_trap || $past(fp_op_done))
        else $error("Cause flags or trap wrong");

    AST_STICKY_SET: assert property (@(posedge clk) disable iff (rst)
        fp_op_done |=> (sticky_flags & $past(exc_masked)) == $past(exc_masked))
        else $error("Masked exception did not set sticky flag");

    AST_STICKY_HOLD: assert property (@(posedge clk) disable iff (rst)
        !fp_op_done && !(cr_we && cr_wr_idx == CRS_CR_FP_STATUS) |=> $stable(sticky_flags))
        else $error("Sticky flags changed without cause");

    AST_VEC_BASE_WRITE: assert property (@(posedge clk) disable iff (rst)
        cr_we && cr_wr_idx == CRS_CR_VEC_BASE |=> vector_table_base == $past(cr_wr_data))
        else $error("Vector table base not written");

    AST_GPR_READ_B: assert property (@(posedge clk) disable iff (rst)
        gpr_rd_b_idx != '0 |=> gpr_rd_b_data == $past(gpr_q[gpr_rd_b_idx]))
        else $error("Port B general register read wrong");

    AST_STICKY_KEEP: assert property (@(posedge clk) disable iff (rst)
        !(cr_we && cr_wr_idx == CRS_CR_FP_STATUS)
        |=> (sticky_flags & $past(sticky_flags)) == $past(sticky_flags))
        else $error("Sticky flag dropped without a software write");

    AST_CR_UNMAPPED: assert property (@(posedge clk) disable iff (rst)
        cr_rd_idx > CRS_CR_FP_STATUS |=> cr_rd_data == CRS_RST_WORD)
        else $error("Unmapped control register read not zero");

    AST_STATUS_KEEP: assert property (@(posedge clk) disable iff (rst)
        fint_accept && !cr_we |=> $stable(status_word))
        else $error("Fast interrupt altered the status word");

endmodule
